/* File: verilog/ifd_pkg.sv */
package ifd_pkg;

   // Register byte offsets
   localparam logic [7:0] IFD_OFS_CTRL = 8'h00;
   localparam logic [7:0] IFD_OFS_INSTR = 8'h04;
   localparam logic [7:0] IFD_OFS_PCTR = 8'h08;
   localparam logic [7:0] IFD_OFS_ACC = 8'h0C;
   localparam logic [7:0] IFD_OFS_QREG = 8'h10;
   localparam logic [7:0] IFD_OFS_BANK0 = 8'h14;
   localparam logic [7:0] IFD_OFS_BANK1 = 8'h18;
   localparam logic [7:0] IFD_OFS_BANK2 = 8'h1C;
   localparam logic [7:0] IFD_OFS_INDEX1 = 8'h20;
   localparam logic [7:0] IFD_OFS_INDEX7 = 8'h38;
   localparam logic [7:0] IFD_OFS_FIELDS = 8'h40;
   localparam logic [7:0] IFD_OFS_EADDR = 8'h44;
   localparam logic [7:0] IFD_OFS_JUMP = 8'h48;

   // Control register fields
   localparam int IFD_CTRL_EXP_BIT = 0;
   localparam int IFD_CTRL_RECOV_BIT = 1;
   localparam logic [1:0] IFD_CTRL_RST = 2'h0;

   // Instruction word layout
   localparam int IFD_F_HI = 29;
   localparam int IFD_F_LO = 24;
   localparam int IFD_F2_HI = 23;
   localparam int IFD_F2_LO = 18;
   localparam int IFD_J_HI = 23;
   localparam int IFD_J_LO = 21;
   localparam int IFD_JH_HI = 23;
   localparam int IFD_JH_LO = 20;
   localparam int IFD_JH2_HI = 12;
   localparam int IFD_JH2_LO = 9;
   localparam int IFD_K_HI = 20;
   localparam int IFD_K_LO = 18;
   localparam int IFD_KH_HI = 19;
   localparam int IFD_KH2_BIT = 8;
   localparam int IFD_B_HI = 17;
   localparam int IFD_B_LO = 15;
   localparam int IFD_S_HI = 14;
   localparam int IFD_S_LO = 13;
   localparam int IFD_Y13_HI = 12;
   localparam int IFD_Y15_HI = 14;
   localparam int IFD_Y8_HI = 7;
   localparam int IFD_P_HI = 16;
   localparam int IFD_P_LO = 13;

   // Codes and fixed values
   localparam logic [5:0] IFD_TYPE2_ESC = 6'h3F;
   localparam logic [5:0] IFD_FAULT_CODE = 6'h00;
   localparam logic [16:0] IFD_FAULT_ADDR0 = 17'h00000;
   localparam logic [16:0] IFD_FAULT_ADDR1 = 17'h00160;
   localparam logic [2:0] IFD_K_COMPAT = 3'h3;
   localparam logic [1:0] IFD_S_PCTR = 2'h3;
   localparam logic [6:0] IFD_CM_INDEX_BASE = 7'h70;
   localparam logic [29:0] IFD_WORD_RST = 30'h00000000;

   typedef struct packed {
      logic type2;
      logic [5:0] fcode;
      logic fault;
      logic [16:0] fault_addr;
      logic [2:0] cond;
      logic [3:0] chan;
      logic [2:0] opmode;
      logic [2:0] idx_sel;
      logic [6:0] idx_cm_addr;
      logic [1:0] ext_sel;
      logic bank_ext;
      logic [16:0] eff_addr;
      logic skip;
      logic ret_jump;
      logic [29:0] ret_word;
      logic [16:0] ret_target;
   } ifd_dec_t;

endpackage

/* File: verilog/ifd_decoder.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Type I function code is instruction bits 29..24.
// - Top six bits octal 77 mean Type II, function from bits 23..18.
// - Function 00 faults and jumps to 00000 or 00540 by recovery switch.
// - Expanded mode memory references use 13-bit operand prefixed with bank bits.
// - Type II operand is bits 7..0 or 12..0 as required.
// - Compatibility mode uses 15-bit operand plus index, no bank bits.
// - Extension field bits 14..13 picks bank 0..2 or counter bits 16..13.
// - Restricted operand modes drop the extension field; operand is 15 bits.
// - Some codes always bank-extend, others only with nonzero short mode.
// - Return jumps store counter plus one, then continue at address plus one.
// - I/O codes 66 and 67 leave the low 15 bits untranslated.
// - Index select bits 17..15 pick index 1..7; zero means none.
// - Index addition is a plain adder; the sum wraps, so nonzero parts can give zero.
// - Using an index register clears its bits above 16 or 14.
// - Index registers live at control memory words 00161..00167.
// - Branch condition is bits 23..21.
// - Outside exceptions, branch condition chooses skip on second or result register.
// - Sign tests look only at the sign bit.
// - I/O channel field is bits 23..20, channels 0 to 15.
// - Type II channel or bank select is bits 12..9.
// - Compatibility format forces operand mode to 3.
// - Operand mode is bits 20..18; short form bits 19..18 or bit 8.
module ifd_decoder
   import ifd_pkg::*;
#(
   parameter int WORD_W = 30,
   parameter int ADDR_W = 17
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Decoded instruction to the sequencer
   output ifd_dec_t DEC,
   output logic DEC_VALID
);

   logic [1:0] ctrl_reg;
   logic [WORD_W-1:0] ir_reg;
   logic ir_valid_reg;
   logic [ADDR_W-1:0] pctr_reg;
   logic [WORD_W-1:0] acc_reg;
   logic [WORD_W-1:0] q_reg;
   logic [3:0] bank_reg [3];
   logic [WORD_W-1:0] index_regs [1:7];
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   logic expanded;
   logic wr_en;
   logic setup;
   ifd_dec_t dec;
   ifd_dec_t fld;
   logic bank_ext;
   logic [ADDR_W-1:0] eff_addr;
   logic skip;
   logic ret_jump;
   logic [WORD_W-1:0] ret_word;
   logic [ADDR_W-1:0] ret_target;
   logic mem_read;
   logic mem_store;
   logic mem_replace;
   logic always_ext;
   logic io_ext;
   logic io_fmt;
   logic no_xlate;
   logic k_restr;
   logic skip_excl;
   logic [1:0] khat;
   logic [3:0] ext_bits;
   logic [ADDR_W-1:0] base;
   logic [ADDR_W-1:0] modifier;
   logic [ADDR_W-1:0] sum;
   logic [WORD_W-1:0] idx_word;
   logic [31:0] rd_mux;
   logic rd_err;
   logic [7:0] op;

   assign expanded = ctrl_reg[IFD_CTRL_EXP_BIT];
   assign setup = PSEL & ~PENABLE;
   assign wr_en = PSEL & PENABLE & PWRITE;

   // Field extraction; address and skip fields are merged in later
   always_comb begin
      fld = '0;
      fld.type2 = (ir_reg[IFD_F_HI:IFD_F_LO] == IFD_TYPE2_ESC);
      if (fld.type2) begin
         fld.fcode = ir_reg[IFD_F2_HI:IFD_F2_LO];
         fld.chan = ir_reg[IFD_JH2_HI:IFD_JH2_LO];
         khat = {1'b0, ir_reg[IFD_KH2_BIT]};
      end else begin
         fld.fcode = ir_reg[IFD_F_HI:IFD_F_LO];
         fld.chan = ir_reg[IFD_JH_HI:IFD_JH_LO];
         khat = ir_reg[IFD_KH_HI:IFD_K_LO];
      end
      fld.fault = (fld.fcode == IFD_FAULT_CODE);
      fld.fault_addr = ctrl_reg[IFD_CTRL_RECOV_BIT] ? IFD_FAULT_ADDR1 : IFD_FAULT_ADDR0;
      fld.cond = ir_reg[IFD_J_HI:IFD_J_LO];
      fld.opmode = expanded ? ir_reg[IFD_K_HI:IFD_K_LO] : IFD_K_COMPAT;
      fld.idx_sel = fld.type2 ? 3'h0 : ir_reg[IFD_B_HI:IFD_B_LO];
      fld.idx_cm_addr = IFD_CM_INDEX_BASE + {4'h0, fld.idx_sel};
      fld.ext_sel = ir_reg[IFD_S_HI:IFD_S_LO];
   end

   // Instruction classes by octal function code
   always_comb begin
      op = {2'h0, fld.fcode};
      mem_read = (op >= 8'o01 && op <= 8'o12) || (op >= 8'o20 && op <= 8'o23)
         || (op >= 8'o26 && op <= 8'o31) || (op >= 8'o40 && op <= 8'o43)
         || (op >= 8'o50 && op <= 8'o53) || op == 8'o70 || op == 8'o71;
      mem_store = (op >= 8'o14 && op <= 8'o16) || op == 8'o32 || op == 8'o33
         || op == 8'o47;
      mem_replace = op == 8'o24 || op == 8'o25 || (op >= 8'o34 && op <= 8'o37)
         || (op >= 8'o44 && op <= 8'o46) || (op >= 8'o54 && op <= 8'o57);
      always_ext = (op >= 8'o60 && op <= 8'o65) || op == 8'o72
         || op == 8'o13 || op == 8'o17;
      io_ext = op >= 8'o73 && op <= 8'o76;
      io_fmt = op == 8'o13 || op == 8'o17 || (op >= 8'o62 && op <= 8'o67)
         || io_ext;
      no_xlate = op == 8'o66 || op == 8'o67;
      skip_excl = op == 8'o04 || op == 8'o12 || op == 8'o13 || op == 8'o16
         || op == 8'o17 || op == 8'o23 || op == 8'o26 || op == 8'o27
         || (op >= 8'o60 && op <= 8'o67) || (op >= 8'o70 && op <= 8'o76);
      k_restr = (fld.opmode == 3'h0) || (fld.opmode == 3'h4)
         || ((fld.opmode == 3'h7) && !mem_store);
   end

   // Bank extension and effective address
   always_comb begin
      bank_ext = 1'b0;
      if (expanded) begin
         if (fld.type2) begin
            bank_ext = (khat != 2'h0);
         end else if (always_ext) begin
            bank_ext = 1'b1;
         end else if (io_ext) begin
            bank_ext = (khat != 2'h0);
         end else if (mem_read || mem_store || mem_replace) begin
            bank_ext = !k_restr;
         end
      end
      ext_bits = (fld.ext_sel == IFD_S_PCTR) ? pctr_reg[IFD_P_HI:IFD_P_LO]
         : bank_reg[fld.ext_sel];
      if (bank_ext) begin
         base = {ext_bits, ir_reg[IFD_Y13_HI:0]};
      end else if (fld.type2) begin
         base = {9'h000, ir_reg[IFD_Y8_HI:0]};
      end else begin
         base = {2'h0, ir_reg[IFD_Y15_HI:0]};
      end
      idx_word = (fld.idx_sel == 3'h0) ? IFD_WORD_RST : index_regs[fld.idx_sel];
      modifier = expanded ? idx_word[ADDR_W-1:0]
         : {2'h0, idx_word[IFD_Y15_HI:0]};
      sum = base + modifier;
      if (no_xlate) begin
         eff_addr = {2'h0, ir_reg[IFD_Y15_HI:0]};
      end else if (expanded) begin
         eff_addr = sum;
      end else begin
         eff_addr = {2'h0, sum[IFD_Y15_HI:0]};
      end
      ret_jump = !fld.type2 && (op == 8'o64 || op == 8'o65);
      ret_word = {{(WORD_W-ADDR_W){1'b0}}, pctr_reg + 17'h00001};
      ret_target = eff_addr + 17'h00001;
   end

   // Skip evaluation
   always_comb begin
      skip = 1'b0;
      if (!fld.type2 && !skip_excl && !io_fmt) begin
         unique case (fld.cond)
            3'h0: skip = 1'b0;
            3'h1: skip = 1'b1;
            3'h2: skip = !q_reg[WORD_W-1];
            3'h3: skip = q_reg[WORD_W-1];
            3'h4: skip = (acc_reg == IFD_WORD_RST);
            3'h5: skip = (acc_reg != IFD_WORD_RST);
            3'h6: skip = !acc_reg[WORD_W-1];
            3'h7: skip = acc_reg[WORD_W-1];
         endcase
      end
   end

   // One process owns the whole decoded word
   always_comb begin
      dec = fld;
      dec.bank_ext = bank_ext;
      dec.eff_addr = eff_addr;
      dec.skip = skip;
      dec.ret_jump = ret_jump;
      dec.ret_word = ret_word;
      dec.ret_target = ret_target;
   end

   assign DEC = dec;
   assign DEC_VALID = ir_valid_reg;

   // Control register
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         ctrl_reg <= IFD_CTRL_RST;
      end else if (wr_en && PADDR == IFD_OFS_CTRL) begin
         ctrl_reg <= PWDATA[1:0];
      end
   end

   // Instruction register; a load makes the decode valid next cycle
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         ir_reg <= IFD_WORD_RST;
         ir_valid_reg <= 1'b0;
      end else begin
         ir_valid_reg <= wr_en && PADDR == IFD_OFS_INSTR;
         if (wr_en && PADDR == IFD_OFS_INSTR) begin
            ir_reg <= PWDATA[WORD_W-1:0];
         end
      end
   end

   // Counter, result and second registers
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         pctr_reg <= '0;
         acc_reg <= IFD_WORD_RST;
         q_reg <= IFD_WORD_RST;
      end else if (wr_en) begin
         if (PADDR == IFD_OFS_PCTR) begin
            pctr_reg <= PWDATA[ADDR_W-1:0];
         end
         if (PADDR == IFD_OFS_ACC) begin
            acc_reg <= PWDATA[WORD_W-1:0];
         end
         if (PADDR == IFD_OFS_QREG) begin
            q_reg <= PWDATA[WORD_W-1:0];
         end
      end
   end

   // Bank registers
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < 3; i++) begin
            bank_reg[i] <= 4'h0;
         end
      end else if (wr_en) begin
         for (int i = 0; i < 3; i++) begin
            if (PADDR == IFD_OFS_BANK0 + 8'(4 * i)) begin
               bank_reg[i] <= PWDATA[3:0];
            end
         end
      end
   end

   // Index registers; a write wins over the use-clear
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 1; i < 8; i++) begin
            index_regs[i] <= IFD_WORD_RST;
         end
      end else begin
         for (int i = 1; i < 8; i++) begin
            if (wr_en && PADDR == IFD_OFS_INDEX1 + 8'(4 * (i - 1))) begin
               index_regs[i] <= PWDATA[WORD_W-1:0];
            end else if (ir_valid_reg && !no_xlate && dec.idx_sel == 3'(i)) begin
               if (expanded) begin
                  index_regs[i] <= {{(WORD_W-ADDR_W){1'b0}},
                     index_regs[i][ADDR_W-1:0]};
               end else begin
                  index_regs[i] <= {15'h0000, index_regs[i][IFD_Y15_HI:0]};
               end
            end
         end
      end
   end

   // Read mux
   always_comb begin
      rd_mux = 32'h00000000;
      rd_err = 1'b0;
      if (PADDR >= IFD_OFS_INDEX1 && PADDR <= IFD_OFS_INDEX7 && PADDR[1:0] == 2'h0) begin
         rd_mux = {2'h0, index_regs[3'(((PADDR - IFD_OFS_INDEX1) >> 2) + 8'h01)]};
      end else begin
         unique case (PADDR)
            IFD_OFS_CTRL: rd_mux = {30'h00000000, ctrl_reg};
            IFD_OFS_INSTR: rd_mux = {2'h0, ir_reg};
            IFD_OFS_PCTR: rd_mux = {15'h0000, pctr_reg};
            IFD_OFS_ACC: rd_mux = {2'h0, acc_reg};
            IFD_OFS_QREG: rd_mux = {2'h0, q_reg};
            IFD_OFS_BANK0: rd_mux = {28'h0000000, bank_reg[0]};
            IFD_OFS_BANK1: rd_mux = {28'h0000000, bank_reg[1]};
            IFD_OFS_BANK2: rd_mux = {28'h0000000, bank_reg[2]};
            IFD_OFS_FIELDS: rd_mux = {6'h00, dec.bank_ext, dec.ext_sel, dec.idx_sel,
               dec.opmode, dec.chan, dec.cond, dec.skip, dec.fault, dec.type2,
               dec.ret_jump, dec.fcode};
            IFD_OFS_EADDR: rd_mux = {15'h0000, dec.eff_addr};
            IFD_OFS_JUMP: rd_mux = {15'h0000,
               dec.fault ? dec.fault_addr : dec.ret_target};
            default: rd_err = 1'b1;
         endcase
      end
   end

   // Read data and error are sampled in the setup cycle
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         prdata_reg <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= PWRITE ? 32'h00000000 : rd_mux;
         pslverr_reg <= rd_err;
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = PSEL & PENABLE;
   assign PSLVERR = PSEL & PENABLE & pslverr_reg;

endmodule

/* File: sim/ifd_decoder_sva.sv */
`timescale 1ns/1ps
module ifd_decoder_sva
   import ifd_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Decode
   input wire ifd_dec_t DEC,
   input wire logic DEC_VALID
);
   logic [29:0] ir_reg;
   logic wr_instr;
   assign wr_instr = PSEL && PENABLE && PWRITE && (PADDR == IFD_OFS_INSTR);
   // Shadow of the loaded instruction word
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         ir_reg <= IFD_WORD_RST;
      end else if (wr_instr) begin
         ir_reg <= PWDATA[29:0];
      end
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   chk_valid_pulse: assert property (wr_instr |=> DEC_VALID ##1 !DEC_VALID)
      else $error("decode valid pulse wrong");
   chk_fcode_one: assert property (DEC_VALID && ir_reg[29:24] != IFD_TYPE2_ESC
      |-> !DEC.type2 && DEC.fcode == ir_reg[29:24]) else $error("type one code wrong");
   chk_fcode_two: assert property (DEC_VALID && ir_reg[29:24] == IFD_TYPE2_ESC
      |-> DEC.type2 && DEC.fcode == ir_reg[23:18]) else $error("type two code wrong");
   chk_fault_flag: assert property (DEC.fault == (DEC.fcode == IFD_FAULT_CODE))
      else $error("fault flag wrong");
   chk_fault_addr: assert property (DEC.fault |-> DEC.fault_addr inside {17'h00000, 17'h00160})
      else $error("fault address wrong");
   chk_cond_field: assert property (DEC_VALID && !DEC.type2 |-> DEC.cond == ir_reg[23:21])
      else $error("condition field wrong");
   chk_index_cm: assert property (DEC_VALID && !DEC.type2 && ir_reg[17:15] != 3'h0
      && ir_reg[29:25] != 5'h1B |-> DEC.idx_sel == ir_reg[17:15]
      && DEC.idx_cm_addr == IFD_CM_INDEX_BASE + ir_reg[17:15]) else $error("index select wrong");
   chk_chan_two: assert property (DEC_VALID && DEC.type2 |-> DEC.chan == ir_reg[12:9])
      else $error("type two channel wrong");
   chk_skip_never: assert property (DEC.cond == 3'h0 || DEC.type2 |-> !DEC.skip)
      else $error("skip without cause");
   chk_ret_target: assert property (DEC.ret_jump |-> DEC.ret_target == DEC.eff_addr + 17'h1)
      else $error("return target wrong");
   chk_io_raw: assert property (DEC_VALID && !DEC.type2 && ir_reg[29:25] == 5'h1B
      |-> DEC.eff_addr == {2'h0, ir_reg[14:0]}) else $error("io operand translated");
endmodule
bind ifd_decoder ifd_decoder_sva u_sva (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .DEC(DEC), .DEC_VALID(DEC_VALID));

/* File: sim/ifd_seq_model.sv */
`timescale 1ns/1ps
module ifd_seq_model
   import ifd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Decode from the block
   input wire ifd_dec_t dec,
   input wire logic dec_valid,
   // Taken decode
   output ifd_dec_t held_dec,
   output logic [7:0] took_count
);
   // Sequencer takes the decode only in the valid cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         held_dec <= '0;
         took_count <= 8'h00;
      end else if (dec_valid) begin
         held_dec <= dec;
         took_count <= took_count + 8'h01;
      end
   end
endmodule

/* File: sim/instruction_field_decoder_tb_top.sv */
`timescale 1ns/1ps
module instruction_field_decoder_tb_top import ifd_pkg::*; ();
   localparam logic [29:0] ONES = 30'h3FFFFFFF;
   logic CORE_CLK, NRST, psel, penable, pwrite, pready, pslverr, dec_valid, rerr;
   logic [7:0] paddr, took_count;
   logic [31:0] pwdata, prdata, rdat;
   ifd_dec_t dec, held_dec;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [2:0] sk_j [7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};
   logic [29:0] sk_a [7] = '{30'h0, 30'h0, 30'h0, 30'h0, 30'h0, ONES, 30'h0};
   logic [29:0] sk_q [7] = '{30'h0, ONES, 30'h0, 30'h0, 30'h0, 30'h0, 30'h0};
   logic sk_e [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   ifd_decoder dut (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .DEC(dec), .DEC_VALID(dec_valid));
   ifd_seq_model model (.clk(CORE_CLK), .nrst(NRST), .dec(dec), .dec_valid(dec_valid),
      .held_dec(held_dec), .took_count(took_count));
   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         summarize();
      end
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge CORE_CLK);
      penable <= 1'b1;
      @(posedge CORE_CLK);
      while (pready !== 1'b1) begin
         @(posedge CORE_CLK);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h00000000);
   endtask
   task ld(input logic [29:0] w);
      wr(IFD_OFS_INSTR, {2'h0, w});
      #1;
      chk("dec_valid", dec_valid, 1);
   endtask
   task t_reset;
      rd(IFD_OFS_CTRL);
      chk("ctrl", rdat, 0);
      chk("fault", dec.fault, 1);
      rd(8'h80);
      chk("unmapped err", rerr, 1);
      chk("unmapped data", rdat, 0);
      $display("test reset done");
   endtask
   task t_compat;
      ld(30'h08205ABC);
      chk("eff", dec.eff_addr, 32'h5ABC);
      chk("opmode", dec.opmode, 3);
      chk("cond", dec.cond, 1);
      chk("skip", dec.skip, 1);
      chk("fcode", dec.fcode, 32'h08);
      wr(IFD_OFS_INDEX1, 32'h3FFF8003);
      ld(30'h08008002);
      chk("eff idx", dec.eff_addr, 5);
      chk("idx cm", dec.idx_cm_addr, 32'h71);
      rd(IFD_OFS_INDEX1);
      chk("index1", rdat, 3);
      chk("taken idx", held_dec.idx_sel, 1);
      $display("test compat done");
   endtask
   task t_skip;
      for (int i = 0; i < 7; i++) begin
         wr(IFD_OFS_ACC, {2'h0, sk_a[i]});
         wr(IFD_OFS_QREG, {2'h0, sk_q[i]});
         ld({6'h08, sk_j[i], 21'h0});
         chk("skip", dec.skip, sk_e[i]);
      end
      $display("test skip done");
   endtask
   task t_type2;
      ld(30'h3FC01400);
      chk("type2", dec.type2, 1);
      chk("fcode2", dec.fcode, 32'h30);
      chk("chan2", dec.chan, 32'hA);
      ld(30'h3F000000);
      chk("fault2", dec.fault, 1);
      wr(IFD_OFS_CTRL, 32'h2);
      rd(IFD_OFS_JUMP);
      chk("jump recov", rdat, 32'h160);
      wr(IFD_OFS_CTRL, 32'h0);
      rd(IFD_OFS_JUMP);
      chk("jump plain", rdat, 0);
      $display("test type2 done");
   endtask
   task t_bank;
      wr(IFD_OFS_CTRL, 32'h1);
      wr(IFD_OFS_PCTR, 32'h1E000);
      wr(IFD_OFS_BANK0, 32'h5);
      ld(30'h340C6123);
      chk("eff pctr", dec.eff_addr, 32'h1E123);
      chk("ret word", dec.ret_word, 32'h1E001);
      chk("ret target", dec.ret_target, 32'h1E124);
      chk("ret jump", dec.ret_jump, 1);
      chk("bank ext", dec.bank_ext, 1);
      ld(30'h340C0123);
      chk("eff bank0", dec.eff_addr, 32'hA123);
      rd(IFD_OFS_FIELDS);
      chk("fields", rdat, 32'h02060074);
      $display("test bank done");
   endtask
   task t_io;
      wr(IFD_OFS_INDEX1 + 8'h04, {2'h0, ONES});
      ld(30'h36B17FFF);
      chk("eff io", dec.eff_addr, 32'h7FFF);
      chk("chan io", dec.chan, 32'hB);
      rd(IFD_OFS_INDEX1 + 8'h04);
      chk("index2", rdat, {2'h0, ONES});
      chk("taken count", took_count, 14);
      $display("test io done");
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      NRST = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      repeat (2) @(posedge CORE_CLK);
      NRST <= 1'b1;
      t_reset();
      t_compat();
      t_skip();
      t_type2();
      t_bank();
      t_io();
      summarize();
   end
endmodule
